// *** rtl/ticc_pkg.sv ***
// Shared constants and types of the timer channel 1/2 I/O control block
package ticc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int unsigned GR_W        = 16;
   localparam int unsigned ADDR_W      = 5;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned NUM_FIELDS  = 4;
   localparam int unsigned CTRL_W      = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_IOCTL_CH1  = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_IOCTL_CH2  = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_GRA_CH1    = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_GRB_CH1    = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_GRA_CH2    = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_GRB_CH2    = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 5'h1C;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [CTRL_W-1:0] IOCTL_RST = 8'h00;
   localparam logic [GR_W-1:0]   GR_RST    = 16'h0000;
   localparam logic [CTRL_W-1:0] STAT_RST  = 8'h00;
   localparam logic [CTRL_W-1:0] MASK_RST  = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Field layout inside one control register
   localparam int unsigned FIELD_A_LSB     = 0;
   localparam int unsigned FIELD_B_LSB     = 4;
   localparam int unsigned FIELD_W         = 4;
   localparam int unsigned MODE_CAPTURE_BIT = 3;
   localparam int unsigned MODE_LEVEL_BIT   = 2;
   localparam int unsigned MODE_BOTH_BIT    = 1;
   localparam int unsigned MODE_FALL_BIT    = 0;

   // Status and mask layout: captures low nibble, matches high nibble
   localparam int unsigned STAT_CAPTURE_LSB = 0;
   localparam int unsigned STAT_MATCH_LSB   = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Compare-match actions held in the two low field bits
   typedef enum logic [1:0] {
      ACT_HOLD   = 2'b00,
      ACT_LOW    = 2'b01,
      ACT_HIGH   = 2'b10,
      ACT_TOGGLE = 2'b11
   } ticc_action_e;

   // Bus answer sequencer
   typedef enum logic [0:0] {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } ticc_bus_e;

endpackage

// *** rtl/ticc_field.sv ***
// One general register with its compare, capture and pin logic
`timescale 1ns/1ps
module ticc_field #(
   parameter bit          CASCADE  = 1'b0,
   parameter int unsigned GR_WIDTH = ticc_pkg::GR_W
) (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic [3:0]            modeCode,
   input  wire logic                  modeWrite,
   input  wire logic [GR_WIDTH-1:0]   counter,
   input  wire logic                  grWrite,
   input  wire logic [GR_WIDTH/8-1:0] grByteEn,
   input  wire logic [GR_WIDTH-1:0]   grWrData,
   input  wire logic                  pinRaw,
   input  wire logic                  cascadeEvt,
   output logic      [GR_WIDTH-1:0]   grValue,
   output logic                       pinOut,
   output logic                       pinOeN,
   output logic                       captureEvt,
   output logic                       matchEvt
);
   import ticc_pkg::*;

   typedef struct packed {
      logic [GR_WIDTH-1:0] gr;
      logic                pin;
      logic [1:0]          sync;
      logic                prevPin;
      logic                prevEqual;
      logic                capture;
      logic                match;
   } ticc_field_s;

   ticc_field_s  st_ff;
   ticc_field_s  nxt_st;
   logic         isCapture;
   logic         rise;
   logic         fall;
   logic         trig;
   logic         equalNow;
   logic         matchNow;
   logic         captureNow;
   ticc_action_e action;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_st       = st_ff;
      isCapture    = modeCode[MODE_CAPTURE_BIT];
      action       = ticc_action_e'(modeCode[1:0]);
      // Second stage alone reads the first
      nxt_st.sync  = {st_ff.sync[0], pinRaw};
      nxt_st.prevPin = st_ff.sync[1];
      rise         = st_ff.sync[1] & ~st_ff.prevPin;
      fall         = ~st_ff.sync[1] & st_ff.prevPin;
      equalNow     = (counter == st_ff.gr);
      nxt_st.prevEqual = equalNow;
      matchNow     = ~isCapture & equalNow & ~st_ff.prevEqual; // R01
      // Edge or cascade selection
      if (CASCADE && modeCode[MODE_LEVEL_BIT]) begin
         trig = cascadeEvt; // R08 R09
      end else if (modeCode[MODE_BOTH_BIT]) begin
         trig = rise | fall; // R07
      end else if (modeCode[MODE_FALL_BIT]) begin
         trig = fall; // R06
      end else begin
         trig = rise; // R05
      end
      captureNow   = isCapture & trig;
      for (int b = 0; b < GR_WIDTH / 8; b++) begin
         if (grWrite && grByteEn[b]) begin
            nxt_st.gr[b*8 +: 8] = grWrData[b*8 +: 8];
         end
      end
      // Capture beats a software write in the same cycle
      if (captureNow) begin
         nxt_st.gr = counter; // R11
      end
      // A new output code other than hold loads its initial level
      if (modeWrite && !isCapture && action != ACT_HOLD) begin
         nxt_st.pin = modeCode[MODE_LEVEL_BIT]; // R04
      end else if (matchNow) begin
         unique case (action)
            ACT_HOLD:   nxt_st.pin = st_ff.pin; // R01
            ACT_LOW:    nxt_st.pin = 1'b0; // R01
            ACT_HIGH:   nxt_st.pin = 1'b1; // R02
            ACT_TOGGLE: nxt_st.pin = ~st_ff.pin; // R03
         endcase
      end
      nxt_st.capture = captureNow;
      nxt_st.match   = matchNow;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff <= '0; // R10
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign grValue    = st_ff.gr;
   assign pinOut     = st_ff.pin;
   assign pinOeN     = modeCode[MODE_CAPTURE_BIT];
   assign captureEvt = st_ff.capture;
   assign matchEvt   = st_ff.match;

endmodule

// *** rtl/ticc_timer_io.sv ***
// Top of the timer channel 1/2 I/O control block with its Avalon-MM slave
//
// Behaviour
// R01: Top bit 0: compare; 0x00 holds, 0x01 low.
// R02: Compare codes x10 drive pin high on match.
// R03: Compare codes x11 toggle pin on match.
// R04: Second-highest bit gives initial compare level.
// R05: Capture mode, low bits 00: rising edge.
// R06: Capture mode, low bits 01: falling edge.
// R07: Low bit1 set: both edges; channel 2 ignores bit2.
// R08: Channel 1 B code 11XX: capture on ch0 C.
// R09: Channel 1 A code 11XX: capture on ch0 A.
// R10: Pins stay low until their code is written.
// R11: Capture copies the counter into the register.
`timescale 1ns/1ps
module ticc_timer_io (
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic [ticc_pkg::ADDR_W-1:0]   avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [ticc_pkg::DATA_W-1:0]   avs_writedata,
   input  wire logic [ticc_pkg::DATA_W/8-1:0] avs_byteenable,
   output logic      [ticc_pkg::DATA_W-1:0]   avs_readdata,
   output logic                               avs_waitrequest,
   input  wire logic [ticc_pkg::GR_W-1:0]     counterCh1,
   input  wire logic [ticc_pkg::GR_W-1:0]     counterCh2,
   input  wire logic                          generalRegACh0Evt,
   input  wire logic                          generalRegCCh0Evt,
   input  wire logic                          pinACh1In,
   output logic                               pinACh1Out,
   output logic                               pinACh1OeN,
   input  wire logic                          pinBCh1In,
   output logic                               pinBCh1Out,
   output logic                               pinBCh1OeN,
   input  wire logic                          pinACh2In,
   output logic                               pinACh2Out,
   output logic                               pinACh2OeN,
   input  wire logic                          pinBCh2In,
   output logic                               pinBCh2Out,
   output logic                               pinBCh2OeN,
   output logic      [ticc_pkg::NUM_FIELDS-1:0] captureEvt,
   output logic      [ticc_pkg::NUM_FIELDS-1:0] matchEvt,
   output logic                               irq
);
   import ticc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      ticc_bus_e             bus;
      logic [CTRL_W-1:0]     ioCtrlCh1;
      logic [CTRL_W-1:0]     ioCtrlCh2;
      logic [CTRL_W-1:0]     status;
      logic [CTRL_W-1:0]     mask;
      logic [NUM_FIELDS-1:0] modeWr;
      logic [DATA_W-1:0]     rdata;
   } ticc_top_s;

   ticc_top_s st_ff;
   ticc_top_s nxt_st;

   // Field order: 0 = A ch1, 1 = B ch1, 2 = A ch2, 3 = B ch2
   logic [FIELD_W-1:0]    fieldCode  [NUM_FIELDS];
   logic [GR_W-1:0]       fieldCount [NUM_FIELDS];
   logic [GR_W-1:0]       fieldGr    [NUM_FIELDS];
   logic [NUM_FIELDS-1:0] fieldGrWr;
   logic [NUM_FIELDS-1:0] fieldCasc;
   logic [NUM_FIELDS-1:0] pinRaw;
   logic [NUM_FIELDS-1:0] pinOut;
   logic [NUM_FIELDS-1:0] pinOeN;
   logic [NUM_FIELDS-1:0] capEvt;
   logic [NUM_FIELDS-1:0] matEvt;
   logic [CTRL_W-1:0]     events;
   logic                  wrTaken;
   logic                  rdStart;
   logic [DATA_W-1:0]     rdMux;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, answer on the second edge
   assign avs_waitrequest = (avs_read | avs_write) & (st_ff.bus == BUS_IDLE);
   assign wrTaken         = avs_write & (st_ff.bus == BUS_ANSWER);
   assign rdStart         = avs_read & (st_ff.bus == BUS_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Field wiring
   assign fieldCode[0]  = st_ff.ioCtrlCh1[FIELD_A_LSB +: FIELD_W];
   assign fieldCode[1]  = st_ff.ioCtrlCh1[FIELD_B_LSB +: FIELD_W];
   assign fieldCode[2]  = st_ff.ioCtrlCh2[FIELD_A_LSB +: FIELD_W];
   assign fieldCode[3]  = st_ff.ioCtrlCh2[FIELD_B_LSB +: FIELD_W];
   assign fieldCount[0] = counterCh1;
   assign fieldCount[1] = counterCh1;
   assign fieldCount[2] = counterCh2;
   assign fieldCount[3] = counterCh2;
   assign fieldCasc     = {1'b0, 1'b0, generalRegCCh0Evt, generalRegACh0Evt}; // R08 R09
   assign pinRaw        = {pinBCh2In, pinACh2In, pinBCh1In, pinACh1In};

   assign fieldGrWr[0]  = wrTaken & (avs_address == OFS_GRA_CH1);
   assign fieldGrWr[1]  = wrTaken & (avs_address == OFS_GRB_CH1);
   assign fieldGrWr[2]  = wrTaken & (avs_address == OFS_GRA_CH2);
   assign fieldGrWr[3]  = wrTaken & (avs_address == OFS_GRB_CH2);

   generate
      for (genvar i = 0; i < NUM_FIELDS; i++) begin : g_field
         ticc_field #(
            .CASCADE  (i < 2),
            .GR_WIDTH (GR_W)
         ) u_field (
            .clk        (clk),
            .reset      (reset),
            .modeCode   (fieldCode[i]),
            .modeWrite  (st_ff.modeWr[i]),
            .counter    (fieldCount[i]),
            .grWrite    (fieldGrWr[i]),
            .grByteEn   (avs_byteenable[GR_W/8-1:0]),
            .grWrData   (avs_writedata[GR_W-1:0]),
            .pinRaw     (pinRaw[i]),
            .cascadeEvt (fieldCasc[i]),
            .grValue    (fieldGr[i]),
            .pinOut     (pinOut[i]),
            .pinOeN     (pinOeN[i]),
            .captureEvt (capEvt[i]),
            .matchEvt   (matEvt[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      rdMux = '0;
      unique case (avs_address)
         OFS_IOCTL_CH1:  rdMux[CTRL_W-1:0] = st_ff.ioCtrlCh1;
         OFS_IOCTL_CH2:  rdMux[CTRL_W-1:0] = st_ff.ioCtrlCh2;
         OFS_GRA_CH1:    rdMux[GR_W-1:0]   = fieldGr[0];
         OFS_GRB_CH1:    rdMux[GR_W-1:0]   = fieldGr[1];
         OFS_GRA_CH2:    rdMux[GR_W-1:0]   = fieldGr[2];
         OFS_GRB_CH2:    rdMux[GR_W-1:0]   = fieldGr[3];
         OFS_IRQ_STATUS: rdMux[CTRL_W-1:0] = st_ff.status;
         OFS_IRQ_MASK:   rdMux[CTRL_W-1:0] = st_ff.mask;
         default:        rdMux = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.modeWr = '0;
      events        = '0;
      events[STAT_CAPTURE_LSB +: NUM_FIELDS] = capEvt;
      events[STAT_MATCH_LSB +: NUM_FIELDS]   = matEvt;

      unique case (st_ff.bus)
         BUS_IDLE: begin
            if (avs_read || avs_write) begin
               nxt_st.bus = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            nxt_st.bus = BUS_IDLE;
         end
      endcase

      if (rdStart) begin
         nxt_st.rdata = rdMux;
      end

      if (wrTaken && avs_byteenable[0]) begin
         unique case (avs_address)
            OFS_IOCTL_CH1: begin
               nxt_st.ioCtrlCh1 = avs_writedata[CTRL_W-1:0];
               nxt_st.modeWr[0] = 1'b1; // R10
               nxt_st.modeWr[1] = 1'b1; // R10
            end
            OFS_IOCTL_CH2: begin
               nxt_st.ioCtrlCh2 = avs_writedata[CTRL_W-1:0];
               nxt_st.modeWr[2] = 1'b1; // R10
               nxt_st.modeWr[3] = 1'b1; // R10
            end
            OFS_IRQ_STATUS: begin
               nxt_st.status = st_ff.status & ~avs_writedata[CTRL_W-1:0];
            end
            OFS_IRQ_MASK: begin
               nxt_st.mask = avs_writedata[CTRL_W-1:0];
            end
            default: begin
               nxt_st.mask = st_ff.mask;
            end
         endcase
      end

      // New events win over a clearing write
      nxt_st.status = nxt_st.status | events;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff.bus       <= BUS_IDLE;
         st_ff.ioCtrlCh1 <= IOCTL_RST;
         st_ff.ioCtrlCh2 <= IOCTL_RST;
         st_ff.status    <= STAT_RST;
         st_ff.mask      <= MASK_RST;
         st_ff.modeWr    <= '0;
         st_ff.rdata     <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign avs_readdata = st_ff.rdata;
   assign irq          = |(st_ff.status & st_ff.mask);
   assign captureEvt   = capEvt;
   assign matchEvt     = matEvt;
   assign pinACh1Out   = pinOut[0];
   assign pinBCh1Out   = pinOut[1];
   assign pinACh2Out   = pinOut[2];
   assign pinBCh2Out   = pinOut[3];
   assign pinACh1OeN   = pinOeN[0];
   assign pinBCh1OeN   = pinOeN[1];
   assign pinACh2OeN   = pinOeN[2];
   assign pinBCh2OeN   = pinOeN[3];

endmodule

// *** verif/ticc_timer_io_props.sv ***
// Port-level checker of the timer channel 1/2 I/O control block
`timescale 1ns/1ps
module ticc_timer_io_props (
   input wire logic                            clk,
   input wire logic                            reset,
   input wire logic [ticc_pkg::ADDR_W-1:0]     avs_address,
   input wire logic                            avs_read,
   input wire logic                            avs_write,
   input wire logic [ticc_pkg::DATA_W-1:0]     avs_writedata,
   input wire logic [ticc_pkg::DATA_W/8-1:0]   avs_byteenable,
   input wire logic                            avs_waitrequest,
   input wire logic                            generalRegACh0Evt,
   input wire logic                            generalRegCCh0Evt,
   input wire logic                            pinACh1Out,
   input wire logic                            pinACh1OeN,
   input wire logic [ticc_pkg::NUM_FIELDS-1:0] captureEvt,
   input wire logic [ticc_pkg::NUM_FIELDS-1:0] matchEvt
);
   import ticc_pkg::*;
   logic       wrCtl;
   logic [7:0] ctl_ff;
   logic [7:0] nxt_ctl;
   ////////////////////////////////////////////////////////////////////////////
   // Shadow of io_control_ch1, updated at the accepting edge
   assign wrCtl = avs_write && !avs_waitrequest && avs_address == OFS_IOCTL_CH1
                  && avs_byteenable[0];
   always_comb begin
      nxt_ctl = wrCtl ? avs_writedata[7:0] : ctl_ff;
   end
   always_ff @(posedge clk) begin
      ctl_ff <= reset ? IOCTL_RST : nxt_ctl;
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_out_cfg;
      wrCtl && !avs_writedata[3] && avs_writedata[1:0] != 2'b00;
   endsequence
   sequence s_init_level;
      ##2 pinACh1Out == $past(avs_writedata[2], 2);
   endsequence
   a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held longer than one cycle");
   a_reset_pins: assert property (disable iff (1'b0) reset |=> !pinACh1Out && !pinACh1OeN)
      else $error("pin not driven low after reset");
   a_oen_mode: assert property (pinACh1OeN == ctl_ff[3])
      else $error("pin enable disagrees with mode");
   a_init_level: assert property (s_out_cfg |-> s_init_level)
      else $error("initial level wrong");
   a_match_low: assert property (matchEvt[0] && ctl_ff[3:0] inside {4'h1, 4'h5} |-> !pinACh1Out)
      else $error("match did not drive low");
   a_match_high: assert property (matchEvt[0] && ctl_ff[3:0] inside {4'h2, 4'h6} |-> pinACh1Out)
      else $error("match did not drive high");
   a_match_toggle: assert property (matchEvt[0] && ctl_ff[3:0] inside {4'h3, 4'h7}
      |-> pinACh1Out != $past(pinACh1Out))
      else $error("match did not toggle");
   a_match_hold: assert property (matchEvt[0] && ctl_ff[3:0] inside {4'h0, 4'h4}
      |-> $stable(pinACh1Out))
      else $error("hold code changed pin");
   a_cascade_a: assert property (generalRegACh0Evt && ctl_ff[3:2] == 2'b11 |=> captureEvt[0])
      else $error("cascade capture A missing");
   a_cascade_b: assert property (generalRegCCh0Evt && ctl_ff[7:6] == 2'b11 |=> captureEvt[1])
      else $error("cascade capture B missing");
endmodule
bind ticc_timer_io ticc_timer_io_props u_props (.clk, .reset, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .generalRegACh0Evt,
   .generalRegCCh0Evt, .pinACh1Out, .pinACh1OeN, .captureEvt, .matchEvt);

// *** verif/ticc_pin_partner.sv ***
// Far-side model: external pin drivers and channel 0 event source
`timescale 1ns/1ps
module ticc_pin_partner (
   input  wire logic       clk,
   input  wire logic [3:0] dutOut,
   input  wire logic [3:0] dutOeN,
   output logic      [3:0] pinLvl,
   output logic            evtA,
   output logic            evtC
);
   logic [3:0] drv = 4'h0;
   initial begin
      evtA = 1'b0;
      evtC = 1'b0;
   end
   // Wire level: the device owns the pin while its enable is low
   assign pinLvl = (dutOeN & drv) | (~dutOeN & dutOut);
   task automatic setPin(input int i, input logic v);
      @(posedge clk);
      drv[i] <= v;
   endtask
   task automatic pulse(input logic selC);
      @(posedge clk);
      if (selC) evtC <= 1'b1; else evtA <= 1'b1;
      @(posedge clk);
      evtA <= 1'b0;
      evtC <= 1'b0;
   endtask
endmodule

// *** verif/ticc_timer_io_tb.sv ***
// Self-checking bench of the timer channel 1/2 I/O control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module ticc_timer_io_tb;
   import ticc_pkg::*;
   logic              clk = 1'b0;
   logic              reset = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0]        avs_byteenable = 4'hF;
   logic [DATA_W-1:0] avs_readdata;
   logic              avs_waitrequest;
   logic [GR_W-1:0]   counterCh1 = '0;
   logic [GR_W-1:0]   counterCh2 = '0;
   wire  [3:0]        pOut, pOeN, pIn, captureEvt, matchEvt;
   wire               generalRegACh0Evt, generalRegCCh0Evt, irq;
   logic [31:0]       rd;
   logic [3:0]        codes [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h6, 4'h0, 4'h4};
   logic              ei, em, prev;
   int                n_errors = 0;
   int                num_checks = 0;
   int                capCnt [4];
   always #2.5 clk = ~clk;
   ticc_timer_io dut (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .counterCh1, .counterCh2,
      .generalRegACh0Evt, .generalRegCCh0Evt, .captureEvt, .matchEvt, .irq,
      .pinACh1In(pIn[0]), .pinACh1Out(pOut[0]), .pinACh1OeN(pOeN[0]),
      .pinBCh1In(pIn[1]), .pinBCh1Out(pOut[1]), .pinBCh1OeN(pOeN[1]),
      .pinACh2In(pIn[2]), .pinACh2Out(pOut[2]), .pinACh2OeN(pOeN[2]),
      .pinBCh2In(pIn[3]), .pinBCh2Out(pOut[3]), .pinBCh2OeN(pOeN[3]));
   ticc_pin_partner pm (.clk, .dutOut(pOut), .dutOeN(pOeN), .pinLvl(pIn),
      .evtA(generalRegACh0Evt), .evtC(generalRegCCh0Evt));
   always @(posedge clk) for (int i = 0; i < 4; i++) if (captureEvt[i] === 1'b1) capCnt[i]++;
   ////////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= ~w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic settle();
      repeat (6) @(posedge clk);
      @(negedge clk);
      capCnt = '{default: 0};
   endtask
   task automatic pinPulse(input int i);
      settle();
      pm.setPin(i, 1'b1);
      repeat (8) @(posedge clk);
      pm.setPin(i, 1'b0);
      repeat (8) @(posedge clk);
   endtask
   task automatic results();
      if (n_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #(5 * 20000);
      n_errors++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      // Zero counters meet zero registers once after reset: all match bits set
      for (int i = 0; i < 8; i++) begin
         bus(5'(4 * i), 1'b0, '0);
         `CHK("reset value", (i == 6) ? 32'hF0 : 32'h0, rd)
      end
      `CHK("pins after reset", 8'h00, {pOut, pOeN})
      bus(5'h02, 1'b0, '0);
      `CHK("unmapped read", 32'h0, rd)
      bus(OFS_GRA_CH1, 1'b1, 32'h0010);
      prev = 1'b0;
      for (int k = 0; k < 8; k++) begin
         ei = (codes[k][1:0] == 2'b00) ? prev : codes[k][2];
         bus(OFS_IOCTL_CH1, 1'b1, {28'h0, codes[k]});
         repeat (3) @(posedge clk);
         `CHK("initial level", ei, pOut[0])
         `CHK("pin enable", 1'b0, pOeN[0])
         counterCh1 <= 16'h0010;
         repeat (3) @(posedge clk);
         case (codes[k][1:0])
            2'b00: em = ei;
            2'b01: em = 1'b0;
            2'b10: em = 1'b1;
            default: em = ~ei;
         endcase
         `CHK("match level", em, pOut[0])
         prev = em;
         counterCh1 <= 16'h0000;
      end
      bus(OFS_IRQ_STATUS, 1'b0, '0);
      `CHK("match status", 32'hF0, rd)
      `CHK("irq masked", 1'b0, irq)
      bus(OFS_IRQ_MASK, 1'b1, 32'h10);
      repeat (2) @(posedge clk);
      `CHK("irq set", 1'b1, irq)
      bus(OFS_IRQ_STATUS, 1'b1, 32'hF0);
      repeat (2) @(posedge clk);
      `CHK("irq cleared", 1'b0, irq)
      bus(OFS_IRQ_MASK, 1'b1, 32'h01);
      for (int k = 8; k < 11; k++) begin
         bus(OFS_IOCTL_CH1, 1'b1, 32'(k));
         @(posedge clk);
         `CHK("input enable", 1'b1, pOeN[0])
         counterCh1 <= 16'(16'h1230 + k);
         pinPulse(0);
         `CHK("edge count", (k >= 10) ? 2 : 1, capCnt[0])
         bus(OFS_GRA_CH1, 1'b0, '0);
         `CHK("captured value", 32'h1230 + k, rd)
      end
      `CHK("irq capture", 1'b1, irq)
      bus(OFS_IRQ_STATUS, 1'b1, 32'h01);
      bus(OFS_IOCTL_CH2, 1'b1, 32'hC0);
      counterCh2 <= 16'h0C0C;
      pinPulse(3);
      `CHK("ch2 rising only", 1, capCnt[3])
      bus(OFS_GRB_CH2, 1'b0, '0);
      `CHK("ch2 captured", 32'h0C0C, rd)
      bus(OFS_IOCTL_CH1, 1'b1, 32'hCC);
      counterCh1 <= 16'h5A5A;
      settle();
      pm.pulse(1'b0);
      repeat (4) @(posedge clk);
      `CHK("cascade a", 1, capCnt[0])
      `CHK("cascade b idle", 0, capCnt[1])
      pm.pulse(1'b1);
      repeat (4) @(posedge clk);
      `CHK("cascade b", 1, capCnt[1])
      bus(OFS_GRA_CH1, 1'b0, '0);
      `CHK("cascade a value", 32'h5A5A, rd)
      bus(OFS_GRB_CH1, 1'b0, '0);
      `CHK("cascade b value", 32'h5A5A, rd)
      results();
   end
endmodule
